// >>> bench/ddds_assertions.sv
// Checker for the link between the debug device end and the host end.
// Assumes it is instantiated beside the interface, on the same mclk.
`timescale 1ns/1ns

module ddds_assertions (
  input wire logic mclk, // Controller clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic req_valid, // Request offered
  input wire logic req_ready, // Device idle
  input wire logic [7:0] req_type, // Descriptor type
  input wire logic [7:0] req_index, // Descriptor index
  input wire logic [15:0] req_len, // Requested length
  input wire logic dat_valid, // Data byte strobe
  input wire logic [7:0] dat_byte, // Data byte
  input wire logic resp_done, // Answer complete
  input wire logic resp_stall // Request refused
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);

  wire logic take_dev = req_valid && req_ready && req_type == 8'h01;
  wire logic take_str = req_valid && req_ready && req_type == 8'h03;

  ////////////////////////////////////////////////////////////////////////////
  // Data flop lags the state change by one edge, so byte k shows k+2 edges after the take
  dev_len_a: assert property (take_dev && req_len != 16'h0000 |->
    ##2 dat_valid && dat_byte == 8'h12) else $error("device length byte wrong");
  dev_type_a: assert property (take_dev && req_len >= 16'h0002 |->
    ##3 dat_valid && dat_byte == 8'h01) else $error("device type byte wrong");
  bcd_usb_a: assert property (take_dev && req_len >= 16'h0004 |->
    ##4 dat_byte == 8'h20 ##1 dat_byte == 8'h03) else $error("release field wrong");
  dev_class_a: assert property (take_dev && req_len >= 16'h0007 |->
    ##6 (dat_valid && dat_byte == 8'h00) [*3]) else $error("class codes not zero");
  max_pkt_a: assert property (take_dev && req_len >= 16'h0008 |->
    ##9 dat_valid && dat_byte == 8'h09) else $error("packet size field wrong");
  str_index_a: assert property (take_dev && req_len >= 16'h0012 |->
    ##16 dat_byte == 8'h01 ##1 dat_byte == 8'h02 ##1 dat_byte == 8'h03
    ##1 dat_byte == 8'h01 && resp_done) else $error("string indices wrong");
  bad_index_a: assert property (take_str && req_index > 8'h03 |=>
    resp_stall && !dat_valid) else $error("bad string index not refused");
  str_fetch_a: assert property (take_str |=> (!dat_valid) [*8])
    else $error("string data before memory fetch");
endmodule : ddds_assertions

// >>> bench/tb.sv
// Testbench joining both ends of the debug descriptor link.
// Assumes a byte memory model answering one cycle after each read strobe.
`timescale 1ns/1ns

module tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] cpu_addr = 8'h00;
  logic [31:0] cpu_wdata = 32'h00000000;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [31:0] cpu_rdata;
  logic mem_rd;
  logic [63:0] mem_addr;
  logic [63:0] ep_out;
  logic [63:0] ep_in;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] mem [4096];
  logic [31:0] d;
  int n_mismatch = 0;
  int compares = 0;
  // Identifier values are arbitrary
  localparam logic [15:0] VID = 16'h1A2B;
  localparam logic [15:0] PID = 16'h3C4D;
  localparam logic [15:0] REV = 16'h0102;
  localparam logic [11:0] SBASE [4] = '{12'h200, 12'h300, 12'h400, 12'h500};
  localparam logic [7:0] SLEN [4] = '{8'h04, 8'h03, 8'h05, 8'h00};
  // Row: type, index, wLength, expected count (FF means refused)
  localparam logic [39:0] ROWS [9] = '{40'h0100001212, 40'h0100000202,
    40'h030000FF04, 40'h030100FF03, 40'h0302000303, 40'h030300FFFF,
    40'h030400FFFF, 40'h02000009FF, 40'h0100000000};

  always #5 mclk = ~mclk;

  ddds_if lnk ();
  ddds_dev i_ddds_dev (.mclk(mclk), .rst(rst), .lnk(lnk), .vendor_id(VID),
    .product_id(PID), .device_rev(REV), .ctx_base(64'h0000000000000100),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .ep_out_ctx_addr(ep_out), .ep_in_ctx_addr(ep_in));
  ddds_host i_ddds_host (.mclk(mclk), .rst(rst), .lnk(lnk), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata));
  ddds_assertions i_ddds_assertions (.mclk(mclk), .rst(rst),
    .req_valid(lnk.req_valid), .req_ready(lnk.req_ready), .req_type(lnk.req_type),
    .req_index(lnk.req_index), .req_len(lnk.req_len), .dat_valid(lnk.dat_valid),
    .dat_byte(lnk.dat_byte), .resp_done(lnk.resp_done), .resp_stall(lnk.resp_stall));

  // Idle memory shows the inverse of its last byte so stale data never passes
  always @(posedge mclk) mem_rdata <= mem_rd ? mem[mem_addr[11:0]] : ~mem_rdata;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge mclk);
    cpu_addr <= a;
    cpu_wdata <= w;
    cpu_wr <= 1'b1;
    @(posedge mclk);
    cpu_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge mclk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge mclk);
    cpu_rd <= 1'b0;
    @(negedge mclk);
    q = cpu_rdata;
  endtask : rd

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_a(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t address %h expected %h", $time, got, exp);
    end
  endtask : chk_a

  task automatic results();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  function automatic logic [7:0] exp_byte(input logic [7:0] t, input logic [7:0] x,
    input int i);
    logic [7:0] dd [18];
    dd = '{8'h12, 8'h01, 8'h20, 8'h03, 8'h00, 8'h00, 8'h00, 8'h09, VID[7:0],
      VID[15:8], PID[7:0], PID[15:8], REV[7:0], REV[15:8], 8'h01, 8'h02, 8'h03, 8'h01};
    if (t == 8'h01)
      return dd[i];
    return mem[SBASE[x[1:0]] + 12'(i)];
  endfunction : exp_byte

  function automatic logic [31:0] cmd(input logic [39:0] r);
    return {r[23:8], r[31:24], r[39:32]};
  endfunction : cmd

  // Poll until idle, then check status and every collected byte
  task automatic finish_row(input logic [39:0] r);
    logic [31:0] q;
    int n;
    q = 32'h00000001;
    n = 0;
    while (q[0] !== 1'b0 && n < 300)
    begin
      rd(8'h04, q);
      n++;
    end
    if (r[7:0] == 8'hFF)
      chk_w(q, 32'h00000002);
    else
    begin
      chk_w(q, {8'h00, r[7:0], 16'h0004});
      for (int i = 0; i < r[7:0]; i++)
      begin
        rd(8'h40 + 8'(i), q);
        chk_w(q, {24'h000000, exp_byte(r[39:32], r[31:24], i)});
      end
    end
  endtask : finish_row

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    results();
  end

  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i * 7 + 3);
    for (int n = 0; n < 4; n++)
    begin
      for (int k = 0; k < 8; k++)
        mem[12'h100 + 12'(8 * n + k)] = 8'h00;
      // Manufacturer pointer carries a stray bit 0 that must be dropped
      mem[12'h100 + 12'(8 * n)] = SBASE[n][7:0] | {7'h00, n == 1};
      mem[12'h101 + 12'(8 * n)] = {4'h0, SBASE[n][11:8]};
      mem[12'h120 + 12'(n)] = SLEN[n];
    end
    // Stream, interval, burst and payload fields of both endpoint contexts are
    // zero; bytes 14h-1Fh stay untouched as the device's own scratch space
    for (int k = 0; k < 20; k++)
    begin
      if (k < 8 || k > 15)
      begin
        mem[12'h140 + 12'(k)] = 8'h00;
        mem[12'h180 + 12'(k)] = 8'h00;
      end
    end
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h04, d);
    chk_w(d, 32'h00000000);
    chk_a(ep_out, 64'h0000000000000140);
    chk_a(ep_in, 64'h0000000000000180);
    foreach (ROWS[i])
    begin
      wr(8'h00, cmd(ROWS[i]));
      finish_row(ROWS[i]);
    end
    // A command while busy is dropped
    wr(8'h00, cmd(40'h030200FF05));
    wr(8'h00, cmd(40'h0100001212));
    finish_row(40'h030200FF05);
    rd(8'h00, d);
    chk_w(d, cmd(40'h030200FF05));
    rd(8'h20, d);
    chk_w(d, 32'h00000000);
    // Reset in the middle of a string fetch, then recover
    wr(8'h00, cmd(40'h030100FF03));
    repeat (6) @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    rd(8'h04, d);
    chk_w(d, 32'h00000000);
    rd(8'h00, d);
    chk_w(d, 32'h00000000);
    chk_a(ep_in, 64'h0000000000000180);
    wr(8'h00, cmd(40'h030300FFFF));
    finish_row(40'h030300FFFF);
    wr(8'h00, cmd(ROWS[0]));
    finish_row(ROWS[0]);
    results();
  end
endmodule : tb

// >>> hdl/ddds_defs.svh
// Constants shared by both ends of the debug descriptor link.
// Assumes nothing; definitions only.
`ifndef DDDS_DEFS_SVH
`define DDDS_DEFS_SVH

// Info context byte offsets
`define DDDS_CTX_STR_PTR_BASE 64'h0000000000000000
`define DDDS_CTX_LEN_WORD 64'h0000000000000020
`define DDDS_CTX_PTR_BYTES 16'h0008

// Endpoint contexts follow the info context, 64 bytes each
`define DDDS_EP_CTX_SIZE 64'h0000000000000040
`define DDDS_EP_OUT_CTX_OFS 64'h0000000000000040
`define DDDS_EP_IN_CTX_OFS 64'h0000000000000080
`define DDDS_EP_SCRATCH_LO 8'h14
`define DDDS_EP_SCRATCH_HI 8'h1F

// Standard descriptor types and string indices
`define DDDS_TYPE_DEVICE 8'h01
`define DDDS_TYPE_STRING 8'h03
`define DDDS_STR_LANG 8'h00
`define DDDS_STR_MANUF 8'h01
`define DDDS_STR_PRODUCT 8'h02
`define DDDS_STR_SERIAL 8'h03

// Device descriptor constant fields
`define DDDS_DEV_LENGTH 8'h12
`define DDDS_DEV_BCD_USB 16'h0320
`define DDDS_DEV_CLASS 8'h00
`define DDDS_DEV_SUBCLASS 8'h00
`define DDDS_DEV_PROTOCOL 8'h00
`define DDDS_DEV_MAXPKT0 8'h09
`define DDDS_DEV_NUM_CONFIG 8'h01

// Host command port map
`define DDDS_HOST_CMD 8'h00
`define DDDS_HOST_STATUS 8'h04
`define DDDS_HOST_BUF 8'h40
`define DDDS_HOST_BUF_DEPTH 32

`endif

// >>> hdl/ddds_dev.sv
// Debug device end: answers GET_DESCRIPTOR for the device and string
// descriptors, fetching string data from system memory.
// Assumes a byte-wide memory read port whose data arrive one cycle after
// the read strobe, and that software fills the info context beforehand.
//
// What this block does
// - Manufacturer pointer at context 08h, bit0 zero
// - Product pointer at 10h, string index 2
// - Serial pointer at 18h, string index 3
// - Length word at 20h holds four byte counts
// - Zero length means pointer is ignored
// - Software zeroes stream fields in endpoint contexts
// - Software zeroes interval, burst, payload fields
// - Endpoint context 64 bytes, 14h-1Fh opaque
// - One interface with bulk IN and OUT
// - Device descriptor length 12h, type 01h, 0320h
// - Class, subclass, protocol all 00h
// - Endpoint zero packet size field 09h
// - Vendor, product, revision from register fields
// - String indices 01h, 02h, 03h
// - One configuration reported
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "ddds_defs.svh"

module ddds_dev (
  input wire logic mclk, // Controller clock
  input wire logic rst, // Asynchronous reset, active high
  ddds_if.dev lnk, // Link to the remote debug host
  input wire logic [15:0] vendor_id, // Vendor identifier field
  input wire logic [15:0] product_id, // Product identifier field
  input wire logic [15:0] device_rev, // Device revision field
  input wire logic [63:0] ctx_base, // Info context base address
  output logic mem_rd, // Memory byte read strobe
  output logic [63:0] mem_addr, // Memory byte address
  input wire logic [7:0] mem_rdata, // Read byte, cycle after strobe
  output logic [63:0] ep_out_ctx_addr, // OUT bulk endpoint context
  output logic [63:0] ep_in_ctx_addr // IN bulk endpoint context
);

  ////////////////////////////////////////////////////////////////////////
  // Device descriptor bytes

  function automatic logic [7:0] desc_byte(
    input logic [4:0] i,
    input logic [15:0] vid,
    input logic [15:0] pid,
    input logic [15:0] rev
  );
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      5'h00: b = `DDDS_DEV_LENGTH;
      5'h01: b = `DDDS_TYPE_DEVICE;
      5'h02: b = 8'(`DDDS_DEV_BCD_USB & 16'h00FF);
      5'h03: b = 8'(`DDDS_DEV_BCD_USB >> 8);
      5'h04: b = `DDDS_DEV_CLASS;
      5'h05: b = `DDDS_DEV_SUBCLASS;
      5'h06: b = `DDDS_DEV_PROTOCOL;
      5'h07: b = `DDDS_DEV_MAXPKT0;
      5'h08: b = vid[7:0];
      5'h09: b = vid[15:8];
      5'h0A: b = pid[7:0];
      5'h0B: b = pid[15:8];
      5'h0C: b = rev[7:0];
      5'h0D: b = rev[15:8];
      5'h0E: b = `DDDS_STR_MANUF;
      5'h0F: b = `DDDS_STR_PRODUCT;
      5'h10: b = `DDDS_STR_SERIAL;
      5'h11: b = `DDDS_DEV_NUM_CONFIG;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : desc_byte

  ////////////////////////////////////////////////////////////////////////
  // State

  ddds_pkg::ddds_dev_state_t state_r;
  logic [1:0] idx_r;
  logic [15:0] want_r;
  logic [15:0] total_r;
  logic [15:0] cnt_r;
  logic [63:0] ptr_r;
  logic pend_r;
  logic dat_valid_r;
  logic [7:0] dat_byte_r;
  logic done_r;
  logic stall_r;
  logic [15:0] str_len_c;
  logic [15:0] clip_c;
  logic last_c;

  assign lnk.req_ready = (state_r == ddds_pkg::DEV_IDLE);
  assign lnk.dat_valid = dat_valid_r;
  assign lnk.dat_byte = dat_byte_r;
  assign lnk.resp_done = done_r;
  assign lnk.resp_stall = stall_r;

  // Length byte just fetched, clipped to the requested wLength
  assign str_len_c = {8'h00, mem_rdata};
  assign clip_c = (want_r < str_len_c) ? want_r : str_len_c;
  assign last_c = (cnt_r == total_r - 16'h0001);

  ////////////////////////////////////////////////////////////////////////
  // Memory read port: one outstanding byte at a time, so data always
  // belong to the address issued in the previous cycle

  always_comb
  begin
    mem_rd = 1'b0;
    mem_addr = 64'h0000000000000000;
    if (!pend_r)
    begin
      unique case (state_r)
        ddds_pkg::DEV_LEN:
        begin
          mem_rd = 1'b1;
          mem_addr = ctx_base + `DDDS_CTX_LEN_WORD + {62'h0, idx_r};
        end
        ddds_pkg::DEV_PTR:
        begin
          mem_rd = 1'b1;
          mem_addr = ctx_base + `DDDS_CTX_STR_PTR_BASE
                     + {59'h0, idx_r, 3'b000} + {61'h0, cnt_r[2:0]};
        end
        ddds_pkg::DEV_STR:
        begin
          mem_rd = 1'b1;
          mem_addr = ptr_r + {48'h0, cnt_r};
        end
        default:
        begin
          mem_rd = 1'b0;
          mem_addr = 64'h0000000000000000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request sequencing and data stage

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ddds_pkg::DEV_IDLE;
      idx_r <= 2'b00;
      want_r <= 16'h0000;
      total_r <= 16'h0000;
      cnt_r <= 16'h0000;
      ptr_r <= 64'h0000000000000000;
      pend_r <= 1'b0;
      dat_valid_r <= 1'b0;
      dat_byte_r <= 8'h00;
      done_r <= 1'b0;
      stall_r <= 1'b0;
    end
    else
    begin
      dat_valid_r <= 1'b0;
      done_r <= 1'b0;
      stall_r <= 1'b0;
      unique case (state_r)
        ddds_pkg::DEV_IDLE:
        begin
          pend_r <= 1'b0;
          cnt_r <= 16'h0000;
          want_r <= lnk.req_len;
          idx_r <= lnk.req_index[1:0];
          if (lnk.req_valid)
          begin
            if (lnk.req_type == `DDDS_TYPE_DEVICE)
            begin
              if (lnk.req_len == 16'h0000)
                done_r <= 1'b1;
              else
              begin
                total_r <= (lnk.req_len < {8'h00, `DDDS_DEV_LENGTH}) ?
                           lnk.req_len : {8'h00, `DDDS_DEV_LENGTH};
                state_r <= ddds_pkg::DEV_DESC;
              end
            end
            else if (lnk.req_type == `DDDS_TYPE_STRING &&
                     lnk.req_index <= `DDDS_STR_SERIAL)
            begin
              if (lnk.req_len == 16'h0000)
                done_r <= 1'b1;
              else
                state_r <= ddds_pkg::DEV_LEN;
            end
            else
              stall_r <= 1'b1;
          end
        end
        ddds_pkg::DEV_DESC:
        begin
          dat_valid_r <= 1'b1;
          dat_byte_r <= desc_byte(cnt_r[4:0], vendor_id, product_id, device_rev);
          cnt_r <= cnt_r + 16'h0001;
          if (last_c)
          begin
            done_r <= 1'b1;
            state_r <= ddds_pkg::DEV_IDLE;
          end
        end
        ddds_pkg::DEV_LEN:
        begin
          pend_r <= !pend_r;
          if (pend_r)
          begin
            if (mem_rdata == 8'h00)
            begin
              stall_r <= 1'b1;
              state_r <= ddds_pkg::DEV_IDLE;
            end
            else
            begin
              total_r <= clip_c;
              cnt_r <= 16'h0000;
              state_r <= ddds_pkg::DEV_PTR;
            end
          end
        end
        ddds_pkg::DEV_PTR:
        begin
          pend_r <= !pend_r;
          if (pend_r)
          begin
            ptr_r[{cnt_r[2:0], 3'b000} +: 8] <= mem_rdata;
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r[2:0] == 3'h7)
            begin
              ptr_r[0] <= 1'b0;
              cnt_r <= 16'h0000;
              state_r <= ddds_pkg::DEV_STR;
            end
          end
        end
        ddds_pkg::DEV_STR:
        begin
          pend_r <= !pend_r;
          if (pend_r)
          begin
            dat_valid_r <= 1'b1;
            dat_byte_r <= mem_rdata;
            cnt_r <= cnt_r + 16'h0001;
            if (last_c)
            begin
              done_r <= 1'b1;
              state_r <= ddds_pkg::DEV_IDLE;
            end
          end
        end
        default:
          state_r <= ddds_pkg::DEV_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Endpoint context addresses for the bulk transfer logic; each context
  // is a fixed 64 bytes whatever the controller's own context size

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ep_out_ctx_addr <= 64'h0000000000000000;
      ep_in_ctx_addr <= 64'h0000000000000000;
    end
    else
    begin
      ep_out_ctx_addr <= ctx_base + `DDDS_EP_OUT_CTX_OFS;
      ep_in_ctx_addr <= ctx_base + `DDDS_EP_OUT_CTX_OFS + `DDDS_EP_CTX_SIZE;
    end
  end

endmodule : ddds_dev

// >>> hdl/ddds_host.sv
// Remote debug host end: issues descriptor requests ordered by software
// and collects the answer bytes in a small flop buffer.
// Assumes a command port with read data one cycle after the read strobe.
`timescale 1ns/1ns
`include "ddds_defs.svh"

module ddds_host (
  input wire logic mclk, // Controller clock
  input wire logic rst, // Asynchronous reset, active high
  ddds_if.host lnk, // Link to the debug device
  input wire logic [7:0] cpu_addr, // Command port byte address
  input wire logic [31:0] cpu_wdata, // Command port write data
  input wire logic cpu_wr, // Write strobe
  input wire logic cpu_rd, // Read strobe
  output logic [31:0] cpu_rdata // Read data, cycle after strobe
);

  ddds_pkg::ddds_host_state_t state_r;
  logic [7:0] type_r;
  logic [7:0] index_r;
  logic [15:0] len_r;
  logic [15:0] count_r;
  logic done_r;
  logic stall_r;
  logic [7:0] buf_r [`DDDS_HOST_BUF_DEPTH];
  logic [7:0] buf_idx_c;
  logic cmd_wr_c;

  assign lnk.req_valid = (state_r == ddds_pkg::HOST_REQ);
  assign lnk.req_type = type_r;
  assign lnk.req_index = index_r;
  assign lnk.req_len = len_r;
  assign cmd_wr_c = cpu_wr && cpu_addr == `DDDS_HOST_CMD;
  assign buf_idx_c = cpu_addr - `DDDS_HOST_BUF;

  ////////////////////////////////////////////////////////////////////////
  // Request sequence; a command while busy is ignored

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ddds_pkg::HOST_IDLE;
      type_r <= 8'h00;
      index_r <= 8'h00;
      len_r <= 16'h0000;
    end
    else
    begin
      unique case (state_r)
        ddds_pkg::HOST_IDLE:
          if (cmd_wr_c)
          begin
            type_r <= cpu_wdata[7:0];
            index_r <= cpu_wdata[15:8];
            len_r <= cpu_wdata[31:16];
            state_r <= ddds_pkg::HOST_REQ;
          end
        ddds_pkg::HOST_REQ:
          if (lnk.req_ready)
            state_r <= ddds_pkg::HOST_WAIT;
        ddds_pkg::HOST_WAIT:
          if (lnk.resp_done || lnk.resp_stall)
            state_r <= ddds_pkg::HOST_IDLE;
        default:
          state_r <= ddds_pkg::HOST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer capture; bytes past the buffer are counted but dropped

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count_r <= 16'h0000;
      done_r <= 1'b0;
      stall_r <= 1'b0;
      for (int i = 0; i < `DDDS_HOST_BUF_DEPTH; i++)
        buf_r[i] <= 8'h00;
    end
    else
    begin
      if (state_r == ddds_pkg::HOST_IDLE && cmd_wr_c)
      begin
        count_r <= 16'h0000;
        done_r <= 1'b0;
        stall_r <= 1'b0;
      end
      else
      begin
        if (lnk.dat_valid)
        begin
          count_r <= count_r + 16'h0001;
          if (count_r < `DDDS_HOST_BUF_DEPTH)
            buf_r[count_r[4:0]] <= lnk.dat_byte;
        end
        if (lnk.resp_done)
          done_r <= 1'b1;
        if (lnk.resp_stall)
          stall_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command port read data

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cpu_rdata <= 32'h00000000;
    else
    begin
      cpu_rdata <= 32'h00000000;
      if (cpu_rd)
      begin
        if (cpu_addr == `DDDS_HOST_STATUS)
          cpu_rdata <= {count_r, 13'h0000, done_r, stall_r,
                        state_r != ddds_pkg::HOST_IDLE};
        else if (cpu_addr == `DDDS_HOST_CMD)
          cpu_rdata <= {len_r, index_r, type_r};
        else if (cpu_addr >= `DDDS_HOST_BUF && buf_idx_c < `DDDS_HOST_BUF_DEPTH)
          cpu_rdata <= {24'h000000, buf_r[buf_idx_c[4:0]]};
      end
    end
  end

endmodule : ddds_host

// >>> hdl/ddds_if.sv
// Link between the debug device end and the remote debug host end.
// Both ends run on the same mclk; the testbench joins them.
`timescale 1ns/1ns

interface ddds_if;
  logic req_valid;
  logic req_ready;
  logic [7:0] req_type;
  logic [7:0] req_index;
  logic [15:0] req_len;
  logic dat_valid;
  logic [7:0] dat_byte;
  logic resp_done;
  logic resp_stall;

  modport dev (
    input req_valid, req_type, req_index, req_len,
    output req_ready, dat_valid, dat_byte, resp_done, resp_stall
  );

  modport host (
    output req_valid, req_type, req_index, req_len,
    input req_ready, dat_valid, dat_byte, resp_done, resp_stall
  );
endinterface : ddds_if

// >>> hdl/ddds_pkg.sv
// Types shared by both ends of the debug descriptor link.
// Assumes the constants header is compiled alongside.
package ddds_pkg;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'b000,
    DEV_DESC = 3'b001,
    DEV_LEN = 3'b010,
    DEV_PTR = 3'b011,
    DEV_STR = 3'b100
  } ddds_dev_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_REQ = 2'b01,
    HOST_WAIT = 2'b10
  } ddds_host_state_t;

endpackage : ddds_pkg
